// ==== hw/mode_regs_map.svh ====
// Constants for the IO configuration and refresh/thermal mode registers
// Assumes inclusion by the two ends of the command link, the link checker and the bench
`ifndef MODE_REGS_MAP_SVH
`define MODE_REGS_MAP_SVH

// ==========================================
// Addresses
`define ADDR_IO_CFG 6'h03
`define ADDR_REFRESH 6'h04
`define ADDR_LATENCY 6'h02
`define ADDR_SET_POINT 6'h0d
// ==========================================
// Field positions
`define IO_PULL_UP_BIT 0
`define IO_POSTAMBLE_BIT 1
`define IO_PROTECT_BIT 2
`define IO_READ_INV_BIT 6
`define IO_WRITE_INV_BIT 7
`define LAT_SET_BIT 6
`define SP_WRITE_BIT 6
`define SP_OP_BIT 7
`define RF_ABORT_BIT 3
`define RF_REPAIR_BIT 4
`define RF_FLAG_BIT 7
`define RF_WRITE_MASK 8'h78
// ==========================================
// Reset values, derated rate and long burst extra count
`define IO_CFG_RESET 8'h31
`define LATENCY_RESET 8'h00
`define RATE_DEFAULT 3'h3
`define RATE_DERATED 3'h6
`define LONG_BURST_EXTRA 5'h08
// ==========================================
// Controller register offsets (AXI4-Lite byte addresses)
`define CSR_CMD 5'h00
`define CSR_STATUS 5'h04
`define CSR_RDATA 5'h08
`define CSR_RL 5'h0c

`endif

// ==== hw/mode_regs_pkg.sv ====
// Command type shared by the two ends of the mode register link, and the controller state type
// Assumes mode_regs_map.svh sits in the include path
package mode_regs_pkg;
	typedef enum logic [1:0] {
		cmd_none = 2'h0,
		cmd_write = 2'h1,
		cmd_read = 2'h2
	} mr_cmd_t;
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_issue = 3'b010,
		st_wait = 3'b100
	} ctl_state_t;
endpackage

// ==== hw/mode_reg_link.sv ====
// Command link between controller and DRAM mode register logic
// Assumes both ends share aclk
`timescale 1ns/10ps
`default_nettype none
interface mode_reg_link (
	input wire logic aclk
);
	import mode_regs_pkg::*;
	mr_cmd_t cmd;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic rvalid;
	logic [7:0] rdata;
	modport ctrl (input aclk, output cmd, output addr, output wdata, input rvalid, input rdata);
	modport dram (input aclk, input cmd, input addr, input wdata, output rvalid, output rdata);
endinterface
`default_nettype wire

// ==== hw/dram_mode_regs.sv ====
// DRAM end: IO configuration and refresh/thermal registers with set points
// Assumes one command per cycle from the controller on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "mode_regs_map.svh"
module dram_mode_regs import mode_regs_pkg::*; #(
	parameter int DENSITY_GB = 4
) (
	input wire logic aresetn,
	mode_reg_link.dram link,
	input wire logic init_done,
	input wire logic [2:0] sensor_rate,
	input wire logic derate_needed,
	input wire logic write_ap_done,
	input wire logic read_ap_done,
	input wire logic long_burst,
	output logic [5:0] read_latency,
	output logic [5:0] write_latency,
	output logic read_inversion_enable,
	output logic write_inversion_enable,
	output logic [2:0] pull_down_strength,
	output logic pull_up_cal_point,
	output logic write_postamble_length,
	output logic repair_protect,
	output logic repair_mode,
	output logic self_refresh_abort_en,
	output logic precharge_start
);
	logic [7:0] io_cfg [2];
	logic [7:0] lat_cfg [2];
	logic [7:0] sp_ctrl;
	logic [7:0] rf_ctrl;
	logic [2:0] rate;
	logic temperature_update_flag;
	logic [5:0] count;
	logic counting;
	logic wsp, osp;
	logic [7:0] act_io, act_lat, rf_read;
	logic wr_io, wr_rf, rd_rf;
	logic [2:0] new_rate;
	logic [4:0] wr_count, rtp_count;

	function automatic logic [5:0] rl_of(input logic [2:0] c, input logic inv);
		logic [5:0] a [8];
		logic [5:0] b [8];
		a = '{6'h06, 6'h0a, 6'h0e, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h24};
		b = '{6'h06, 6'h0c, 6'h10, 6'h16, 6'h1c, 6'h20, 6'h24, 6'h28};
		return inv ? b[c] : a[c];
	endfunction
	function automatic logic [5:0] wl_of(input logic [2:0] c, input logic setb);
		logic [5:0] a [8];
		logic [5:0] b [8];
		a = '{6'h04, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h10, 6'h12};
		b = '{6'h04, 6'h08, 6'h0c, 6'h12, 6'h16, 6'h1a, 6'h1e, 6'h22};
		return setb ? b[c] : a[c];
	endfunction

	assign wsp = sp_ctrl[`SP_WRITE_BIT];
	assign osp = sp_ctrl[`SP_OP_BIT];
	assign act_io = io_cfg[osp];
	assign act_lat = lat_cfg[osp];
	assign wr_io = link.cmd == cmd_write && link.addr == `ADDR_IO_CFG;
	assign wr_rf = link.cmd == cmd_write && link.addr == `ADDR_REFRESH;
	assign rd_rf = link.cmd == cmd_read && link.addr == `ADDR_REFRESH;
	assign rf_read = {temperature_update_flag, rf_ctrl[6:3], rate};
	assign new_rate = derate_needed ? `RATE_DERATED : sensor_rate;
	always_comb begin
		unique case (act_lat[2:0])
			3'h4: rtp_count = 5'h0a;
			3'h5: rtp_count = 5'h0c;
			3'h6: rtp_count = 5'h0e;
			3'h7: rtp_count = 5'h10;
			default: rtp_count = 5'h08;
		endcase
		unique case (act_lat[5:3])
			3'h0: wr_count = 5'h06;
			3'h1: wr_count = 5'h0a;
			3'h2: wr_count = 5'h10;
			3'h3: wr_count = 5'h14;
			3'h4: wr_count = 5'h18;
			3'h5: wr_count = 5'h1e;
			3'h6: wr_count = 5'h22;
			default: wr_count = 5'h28;
		endcase
	end

	// ==========================================
	// Set point and latency registers
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			sp_ctrl <= 8'h00;
			lat_cfg[0] <= `LATENCY_RESET;
			lat_cfg[1] <= `LATENCY_RESET;
		end else if (link.cmd == cmd_write && link.addr == `ADDR_SET_POINT) begin
			sp_ctrl <= link.wdata;
		end else if (link.cmd == cmd_write && link.addr == `ADDR_LATENCY) begin
			lat_cfg[wsp] <= link.wdata;
		end
	end

	// ==========================================
	// IO configuration copies
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			io_cfg[0] <= `IO_CFG_RESET;
			io_cfg[1] <= `IO_CFG_RESET;
		end else if (wr_io) begin
			io_cfg[wsp] <= link.wdata;
			io_cfg[wsp][`IO_PROTECT_BIT] <= link.wdata[`IO_PROTECT_BIT] | repair_protect;
		end
	end

	// ==========================================
	// Refresh, repair and thermal register
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			rf_ctrl <= 8'h00;
		end else if (wr_rf) begin
			rf_ctrl[6:5] <= link.wdata[6:5];
			rf_ctrl[`RF_ABORT_BIT] <= link.wdata[`RF_ABORT_BIT];
			if (!(repair_protect && link.wdata[`RF_REPAIR_BIT])) begin
				rf_ctrl[`RF_REPAIR_BIT] <= link.wdata[`RF_REPAIR_BIT];
			end
		end
	end
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			rate <= `RATE_DEFAULT;
			temperature_update_flag <= 1'b0;
		end else if (init_done) begin
			rate <= new_rate;
			if (new_rate != rate) begin
				temperature_update_flag <= 1'b1;
			end else if (rd_rf) begin
				temperature_update_flag <= 1'b0;
			end
		end else if (rd_rf) begin
			temperature_update_flag <= 1'b0;
		end
	end

	// ==========================================
	// Read answer
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			link.rvalid <= 1'b0;
			link.rdata <= 8'h00;
		end else begin
			link.rvalid <= link.cmd == cmd_read;
			if (link.cmd == cmd_read) begin
				if (link.addr == `ADDR_IO_CFG) link.rdata <= io_cfg[wsp];
				else if (link.addr == `ADDR_REFRESH) link.rdata <= rf_read;
				else if (link.addr == `ADDR_LATENCY) link.rdata <= lat_cfg[wsp];
				else if (link.addr == `ADDR_SET_POINT) link.rdata <= sp_ctrl;
				else link.rdata <= 8'h00;
			end
		end
	end

	// ==========================================
	// Auto precharge delay
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			count <= 6'h00;
			counting <= 1'b0;
			precharge_start <= 1'b0;
		end else begin
			precharge_start <= 1'b0;
			if (write_ap_done) begin
				count <= {1'b0, wr_count} - 6'h01;
				counting <= 1'b1;
			end else if (read_ap_done) begin
				count <= (long_burst ? {1'b0, rtp_count} + {1'b0, `LONG_BURST_EXTRA}
					: {1'b0, rtp_count}) - 6'h01;
				counting <= 1'b1;
			end else if (counting) begin
				if (count == 6'h00) begin
					counting <= 1'b0;
					precharge_start <= 1'b1;
				end else begin
					count <= count - 6'h01;
				end
			end
		end
	end

	// ==========================================
	// Operating outputs from active set point; repair and abort outputs from write data and refresh register
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			read_latency <= 6'h06;
			write_latency <= 6'h04;
			read_inversion_enable <= 1'b0;
			write_inversion_enable <= 1'b0;
			pull_down_strength <= 3'h6;
			pull_up_cal_point <= 1'b1;
			write_postamble_length <= 1'b0;
			repair_protect <= 1'b0;
			repair_mode <= 1'b0;
			self_refresh_abort_en <= 1'b0;
		end else begin
			read_latency <= rl_of(act_lat[2:0], act_io[`IO_READ_INV_BIT]);
			write_latency <= wl_of(act_lat[5:3], act_lat[`LAT_SET_BIT]);
			read_inversion_enable <= act_io[`IO_READ_INV_BIT];
			write_inversion_enable <= act_io[`IO_WRITE_INV_BIT];
			pull_down_strength <= act_io[5:3];
			pull_up_cal_point <= act_io[`IO_PULL_UP_BIT];
			write_postamble_length <= act_io[`IO_POSTAMBLE_BIT];
			repair_protect <= repair_protect | (wr_io & link.wdata[`IO_PROTECT_BIT]);
			repair_mode <= rf_ctrl[`RF_REPAIR_BIT];
			self_refresh_abort_en <= rf_ctrl[`RF_ABORT_BIT] && DENSITY_GB >= 12;
		end
	end
endmodule // dram_mode_regs
`default_nettype wire

// ==== hw/mode_reg_ctrl.sv ====
// Controller end: AXI4-Lite registers that issue mode register commands
// Assumes one AXI4-Lite master on aclk
`timescale 1ns/10ps
`default_nettype none
`include "mode_regs_map.svh"
module mode_reg_ctrl import mode_regs_pkg::*; (
	input wire logic aresetn,
	mode_reg_link.ctrl link,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	ctl_state_t state;
	logic have_aw, have_w;
	logic [4:0] aw;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [7:0] last_rdata;
	logic [7:0] rate_seen;
	logic busy_read;

	// ==========================================
	// Write channel capture
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			aw <= 5'h00;
			wd <= 32'h0;
			ws <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw <= s_axi_awaddr;
				have_aw <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd <= s_axi_wdata;
				ws <= s_axi_wstrb;
				have_w <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (have_aw && have_w && !s_axi_bvalid && state == st_idle) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw == `CSR_CMD) ? 2'h0 : 2'h2;
				have_aw <= 1'b0;
				have_w <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ==========================================
	// Command sequencer
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			state <= st_idle;
			link.cmd <= cmd_none;
			link.addr <= 6'h00;
			link.wdata <= 8'h00;
			busy_read <= 1'b0;
		end else begin
			unique case (state)
				st_idle: begin
					if (have_aw && have_w && !s_axi_bvalid && aw == `CSR_CMD && ws[0]) begin
						link.addr <= wd[13:8];
						link.wdata <= wd[7:0];
						link.cmd <= wd[16] ? cmd_read : cmd_write;
						busy_read <= wd[16];
						state <= st_issue;
					end
				end
				st_issue: begin
					link.cmd <= cmd_none;
					state <= busy_read ? st_wait : st_idle;
				end
				st_wait: begin
					if (link.rvalid) begin
						state <= st_idle;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Read results
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			last_rdata <= 8'h00;
			rate_seen <= 8'h00;
		end else if (state == st_wait && link.rvalid) begin
			last_rdata <= link.rdata;
			if (link.addr == `ADDR_REFRESH) rate_seen <= link.rdata;
		end
	end

	// ==========================================
	// AXI4-Lite read channel
	always_ff @(posedge link.aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			unique case (s_axi_araddr)
				`CSR_CMD: s_axi_rdata <= {16'h0, 2'h0, link.addr, link.wdata};
				`CSR_STATUS: s_axi_rdata <= {31'h0, state != st_idle};
				`CSR_RDATA: s_axi_rdata <= {24'h0, last_rdata};
				`CSR_RL: s_axi_rdata <= {24'h0, rate_seen[7],
					(rate_seen[2:0] == 3'h0 || rate_seen[2:0] == 3'h7),
					3'h0, rate_seen[2:0]};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // mode_reg_ctrl
`default_nettype wire

// ==== bench/mode_reg_link_chk.sv ====
// Assertions on the mode register link
// Assumes instantiation beside the link, on aclk and aresetn
`timescale 1ns/10ps
`default_nettype none
`include "mode_regs_map.svh"
module mode_reg_link_chk import mode_regs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] cmd,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic rvalid,
	input wire logic [7:0] rdata
);
	logic [5:0] raddr;
	logic wsp;
	logic prot;
	logic [7:0] rf;
	logic [7:0] io [2];
	wire logic wr_io = cmd == cmd_write && addr == `ADDR_IO_CFG;
	wire logic wr_rf = cmd == cmd_write && addr == `ADDR_REFRESH;
	// ========
	// Expected register state
	always_ff @(posedge aclk) begin
		if (cmd == cmd_read)
			raddr <= addr;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wsp <= 1'b0;
			prot <= 1'b0;
			rf <= 8'h00;
			io <= '{`IO_CFG_RESET, `IO_CFG_RESET};
		end else begin
			if (cmd == cmd_write && addr == `ADDR_SET_POINT)
				wsp <= wdata[`SP_WRITE_BIT];
			if (wr_io && wdata[`IO_PROTECT_BIT])
				prot <= 1'b1;
			if (wr_io)
				io[wsp] <= wdata | {5'h00, prot, 2'h0};
			if (wr_rf)
				rf <= wdata & `RF_WRITE_MASK;
			if (wr_rf && prot)
				rf[4] <= wdata[4] & rf[4];
		end
	end
	// ========
	// Properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_cmd_pulse;
		cmd != cmd_none |=> cmd == cmd_none;
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse)
		else $error("link command not a pulse");
	property p_read_answer;
		cmd == cmd_read |=> rvalid ##1 !rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read answer late or long");
	property p_write_silent;
		cmd == cmd_write |=> !rvalid;
	endproperty
	a_write_silent: assert property (p_write_silent)
		else $error("answer after a write");
	property p_rvalid_cause;
		rvalid |-> $past(cmd) == cmd_read;
	endproperty
	a_rvalid_cause: assert property (p_rvalid_cause)
		else $error("answer without a read");
	property p_rdata_stands;
		!rvalid && $past(aresetn) |-> $stable(rdata);
	endproperty
	a_rdata_stands: assert property (p_rdata_stands)
		else $error("read data moved");
	property p_io_read;
		rvalid && raddr == `ADDR_IO_CFG |-> rdata == io[wsp];
	endproperty
	a_io_read: assert property (p_io_read)
		else $error("io config copy mismatch");
	property p_rf_read;
		rvalid && raddr == `ADDR_REFRESH |-> (rdata & `RF_WRITE_MASK) == rf;
	endproperty
	a_rf_read: assert property (p_rf_read)
		else $error("refresh bits mismatch");
	property p_unknown;
		rvalid && !(raddr inside {`ADDR_LATENCY, `ADDR_IO_CFG, `ADDR_REFRESH, `ADDR_SET_POINT})
			|-> rdata == 8'h00;
	endproperty
	a_unknown: assert property (p_unknown)
		else $error("unknown address not zero");
	c_rf_read: cover property (rvalid && raddr == `ADDR_REFRESH);
	c_refused: cover property (wr_rf && prot && wdata[`RF_REPAIR_BIT]);
	c_sp1: cover property (wr_io && wsp);
endmodule // mode_reg_link_chk
`default_nettype wire

// ==== bench/testbench.sv ====
// Bench joining controller and DRAM ends of the mode register link
// Assumes the hw package, header and interface compiled first
`timescale 1ns/10ps
`default_nettype none
`include "mode_regs_map.svh"
module testbench;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, init_done, derate_needed, wap, rap, long_burst;
	logic rinv, winv, pu, pst, prot, rep, abort, pre;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, r;
	logic [1:0] bresp, rresp, resp;
	logic [2:0] sensor_rate, pds;
	logic [5:0] rl, wl;
	logic [7:0] q;
	int num_errors = 0, checked = 0, cycles = 0;
	wire logic [9:0] io_bits = {rinv, winv, pds, pu, pst, prot, rep, abort};
	logic [5:0] lat [4][8] = '{'{6'h06, 6'h0a, 6'h0e, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h24},
		'{6'h06, 6'h0c, 6'h10, 6'h16, 6'h1c, 6'h20, 6'h24, 6'h28},
		'{6'h04, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h10, 6'h12},
		'{6'h04, 6'h08, 6'h0c, 6'h12, 6'h16, 6'h1a, 6'h1e, 6'h22}};
	mode_reg_link link (.aclk(aclk));
	mode_reg_ctrl mode_reg_ctrl_i (.aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	dram_mode_regs #(.DENSITY_GB(16)) dram_mode_regs_i (.aresetn(aresetn), .link(link),
		.init_done(init_done), .sensor_rate(sensor_rate), .derate_needed(derate_needed),
		.write_ap_done(wap), .read_ap_done(rap), .long_burst(long_burst), .read_latency(rl),
		.write_latency(wl), .read_inversion_enable(rinv), .write_inversion_enable(winv),
		.pull_down_strength(pds), .pull_up_cal_point(pu), .write_postamble_length(pst),
		.repair_protect(prot), .repair_mode(rep), .self_refresh_abort_en(abort),
		.precharge_start(pre));
	mode_reg_link_chk mode_reg_link_chk_i (.aclk(aclk), .aresetn(aresetn), .cmd(link.cmd),
		.addr(link.addr), .wdata(link.wdata), .rvalid(link.rvalid), .rdata(link.rdata));
	// ========
	// Tasks
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked = checked + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic mr(input logic rd, input logic [5:0] a, input logic [7:0] d);
		axi_write(`CSR_CMD, {15'h0, rd, 2'h0, a, d}, resp);
		do
			axi_read(`CSR_STATUS, r, resp);
		while (r[0]);
		axi_read(`CSR_RDATA, r, resp);
		q = r[7:0];
	endtask
	task automatic rate(input logic i, input logic [2:0] s, input logic d, input logic [7:0] e);
		@(posedge aclk);
		init_done <= i;
		sensor_rate <= s;
		derate_needed <= d;
		mr(1'b1, `ADDR_REFRESH, 8'h00);
		chk("refresh_read", e, q);
	endtask
	task automatic ap(input logic w, input logic lng, input int n);
		int k;
		@(posedge aclk);
		wap <= w;
		rap <= !w;
		long_burst <= lng;
		@(posedge aclk);
		wap <= 1'b0;
		rap <= 1'b0;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (!pre && k < 100);
		chk("precharge_delay", n + 1, k);
	endtask
	// ========
	// Clock, timeout and sequence
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			num_errors = num_errors + 1;
			summarize();
		end
	end
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, wap, rap, long_burst} = 8'h00;
		{awaddr, araddr, wdata, init_done, derate_needed} = 44'h0;
		sensor_rate = 3'h5;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("latency", {6'h06, 6'h04}, {rl, wl});
		chk("io_outputs", 10'h0d0, io_bits);
		mr(1'b1, `ADDR_IO_CFG, 8'h00);
		chk("io_read", 8'h31, q);
		rate(1'b0, 3'h5, 1'b0, 8'h03);
		rate(1'b1, 3'h5, 1'b0, 8'h85);
		rate(1'b1, 3'h5, 1'b0, 8'h05);
		rate(1'b1, 3'h1, 1'b0, 8'h81);
		rate(1'b1, 3'h2, 1'b0, 8'h82);
		rate(1'b1, 3'h4, 1'b0, 8'h84);
		rate(1'b1, 3'h4, 1'b1, 8'h86);
		axi_read(`CSR_RL, r, resp);
		chk("rate_status", 32'h86, r);
		chk("axi_resp", 2'h0, resp);
		rate(1'b1, 3'h7, 1'b0, 8'h87);
		axi_read(`CSR_RL, r, resp);
		chk("rate_status", 32'hc7, r);
		rate(1'b1, 3'h3, 1'b0, 8'h83);
		for (int m = 0; m < 2; m++) begin
			mr(1'b0, `ADDR_IO_CFG, {1'b0, m[0], 6'h31});
			for (int i = 0; i < 8; i++) begin
				mr(1'b0, `ADDR_LATENCY, {1'b0, m[0], i[2:0], i[2:0]});
				chk("latency", {lat[m][i], lat[m + 2][i]}, {rl, wl});
			end
		end
		mr(1'b0, `ADDR_IO_CFG, 8'h31);
		mr(1'b0, `ADDR_LATENCY, 8'h00);
		ap(1'b1, 1'b0, 6);
		ap(1'b0, 1'b0, 8);
		ap(1'b0, 1'b1, 16);
		mr(1'b0, `ADDR_SET_POINT, 8'h40);
		mr(1'b0, `ADDR_IO_CFG, 8'ha9);
		chk("io_outputs", 10'h0d0, io_bits);
		mr(1'b1, `ADDR_IO_CFG, 8'h00);
		chk("io_read", 8'ha9, q);
		mr(1'b0, `ADDR_SET_POINT, 8'hc0);
		chk("io_outputs", 10'h1b0, io_bits);
		mr(1'b0, `ADDR_SET_POINT, 8'h00);
		mr(1'b1, `ADDR_IO_CFG, 8'h00);
		chk("io_read", 8'h31, q);
		mr(1'b0, `ADDR_REFRESH, 8'h18);
		chk("io_outputs", 10'h0d3, io_bits);
		mr(1'b0, `ADDR_REFRESH, 8'h00);
		chk("io_outputs", 10'h0d0, io_bits);
		mr(1'b0, `ADDR_IO_CFG, 8'h35);
		mr(1'b0, `ADDR_IO_CFG, 8'h31);
		chk("io_outputs", 10'h0d4, io_bits);
		mr(1'b0, `ADDR_REFRESH, 8'hff);
		chk("io_outputs", 10'h0d5, io_bits);
		mr(1'b1, `ADDR_REFRESH, 8'h00);
		chk("refresh_read", 8'h6b, q);
		mr(1'b1, 6'h10, 8'h00);
		chk("unknown_read", 8'h00, q);
		axi_read(5'h14, r, resp);
		chk("axi_resp", 2'h2, resp);
		axi_write(5'h1c, 32'h0, resp);
		chk("axi_resp", 2'h2, resp);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("io_outputs", 10'h0d0, io_bits);
		mr(1'b1, `ADDR_IO_CFG, 8'h00);
		chk("io_read", 8'h31, q);
		rate(1'b1, 3'h3, 1'b0, 8'h03);
		summarize();
	end
endmodule // testbench
`default_nettype wire
